// [verilog/frac_defines.vh]
// Constants for the flash rewrite and access controller.
// Assumes inclusion by bare name; definitions only.
`ifndef FRAC_DEFINES_VH
`define FRAC_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define FRAC_OFS_CTRL0 12'h000
`define FRAC_OFS_CTRL1 12'h004
`define FRAC_OFS_CMD 12'h008
`define FRAC_OFS_SRD 12'h00c
`define FRAC_OFS_LOCK 12'h010
`define FRAC_OFS_CPB 12'h014
`define FRAC_OFS_CTLBLK 12'h018
`define FRAC_OFS_INFO 12'h01c

// ****************************************
// Field positions
// ****************************************
`define FRAC_C0_READY 0
`define FRAC_C0_REWR_EN 1
`define FRAC_C0_LOCK_DIS 2
`define FRAC_C0_AREA_SEL 5
`define FRAC_C0_PERR 6
`define FRAC_C0_EERR 7
`define FRAC_C1_MODE_SEL 1
`define FRAC_C1_LOCK_STAT 7
`define FRAC_SR_READY 7
`define FRAC_SR_EERR 5
`define FRAC_SR_PERR 4
`define FRAC_CPL_HI 7
`define FRAC_CPL_LO 6

// ****************************************
// Commands, reset values and compare constants
// ****************************************
`define FRAC_CMD_PROG 3'h0
`define FRAC_CMD_BERASE 3'h1
`define FRAC_CMD_EALL 3'h2
`define FRAC_CMD_CLRST 3'h3
`define FRAC_CMD_RDSTAT 3'h4
`define FRAC_CMD_LOCKPRG 3'h5
`define FRAC_CMD_LOCKRD 3'h6
`define FRAC_CPB_RESET 8'hff
`define FRAC_CPB_ERASED 8'hff
`define FRAC_CPB_CLEAR 8'h00
`define FRAC_CPL_OFF 2'h3
`define FRAC_VEC_BLANK 32'hffffffff
`define FRAC_ID_BYTES 3'h7
`define FRAC_STRAP_WAIT 2'h3

`endif

// [verilog/frac_ctrl.v]
// Flash rewrite access controller: boot strap capture, area select,
// block locks, code protect, serial ID check and CPU rewrite sequencing.
// Assumes a flash macro on pclk that runs each operation and answers done.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "frac_defines.vh"

module frac_ctrl #(
  parameter NBLK = 8,
  parameter CP_BLOCK = 0
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Strap and mode pins
  input wire boot_select_pin,
  input wire port5_bit0_strap,
  input wire port5_bit5_strap,
  input wire par_mode_pin,
  input wire ser_mode_pin,
  // Serial programmer ID bytes and stored flash contents
  input wire id_valid,
  input wire [7:0] id_byte,
  input wire [55:0] stored_id,
  input wire [31:0] reset_vector,
  // Flash macro operation port
  output reg op_req,
  output reg [2:0] op_cmd,
  output reg [3:0] op_block,
  input wire op_done,
  input wire op_fail,
  // Mode outputs
  output reg boot_mode,
  output reg boot_area_sel,
  output reg read_status_mode,
  output reg cpu_hold,
  output reg par_blocked,
  output reg ser_accept
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [4:0] sync1_r;
  reg [4:0] sync2_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else begin
      sync1_r <= {ser_mode_pin, par_mode_pin, port5_bit5_strap, port5_bit0_strap,
                  boot_select_pin};
      sync2_r <= sync1_r;
    end
  end
  wire par_mode_s = sync2_r[3];
  wire ser_mode_s = sync2_r[4];

  // ****************************************
  // Strap capture after reset release
  // ****************************************
  // Wait until the synchronisers hold real pin levels before latching
  reg [1:0] strap_cnt_r;
  reg strap_done_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
      boot_mode <= 1'b0;
    end else if (!strap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == `FRAC_STRAP_WAIT) begin
        strap_done_r <= 1'b1;
        boot_mode <= sync2_r[0] & sync2_r[1] & ~sync2_r[2];
      end
    end
  end

  // ****************************************
  // APB handshake, one wait state
  // ****************************************
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire bus_ph = psel & penable & ~pready;
  reg rewr_en_r, lock_dis_r, area_sel_r, mode_sel_r, arm_en_r, arm_mode_r, arm_ld_r;
  reg perr_r, eerr_r, lock_stat_r, busy_r;
  reg [NBLK-1:0] lock_r;
  reg [7:0] cpb_r;
  reg [3:0] ctl_blk_r, cur_blk_r;
  reg [2:0] cur_cmd_r;

  // ****************************************
  // Code protect decode
  // ****************************************
  wire [1:0] cp_level = cpb_r[`FRAC_CPL_HI:`FRAC_CPL_LO];
  // Low six bits are the writer's burden; only the clear and erased byte compares look at them
  wire cp_active = (cp_level != `FRAC_CPL_OFF) & (cpb_r != `FRAC_CPB_CLEAR) &
                   (cpb_r != `FRAC_CPB_ERASED);

  // ****************************************
  // Command decode and acceptance
  // ****************************************
  wire cmd_wr = wr & (paddr == `FRAC_OFS_CMD);
  wire [2:0] cmd = pwdata[2:0];
  wire [3:0] cblk = pwdata[11:8];
  wire blk_ok = (cblk < NBLK);
  wire blk_lock = blk_ok ? ~lock_r[cblk[2:0]] : 1'b1;
  wire ctl_unlk = lock_r[ctl_blk_r[2:0]];
  // Boot mode with area select 0 leaves only the boot area, which CPU cannot alter
  wire area_ok = ~boot_mode | area_sel_r;
  wire is_erase = (cmd == `FRAC_CMD_BERASE) | (cmd == `FRAC_CMD_EALL);
  wire is_op = (cmd == `FRAC_CMD_PROG) | is_erase | (cmd == `FRAC_CMD_LOCKPRG) |
               (cmd == `FRAC_CMD_LOCKRD);
  reg refuse;
  always @* begin
    refuse = 1'b0;
    if (!area_ok || !rewr_en_r) begin
      refuse = 1'b1;
    end else if (cmd == `FRAC_CMD_EALL) begin
      refuse = mode_sel_r & (ctl_unlk | lock_dis_r);
    end else if (!blk_ok) begin
      refuse = 1'b1;
    end else if ((cmd == `FRAC_CMD_PROG) || (cmd == `FRAC_CMD_BERASE)) begin
      refuse = (blk_lock & ~lock_dis_r) |
               (mode_sel_r & (cblk == ctl_blk_r));
    end
  end
  // Commands only count with rewrite enabled and no operation running
  wire go = cmd_wr & rewr_en_r & ~busy_r & is_op & ~refuse;
  wire bad = cmd_wr & rewr_en_r & ~busy_r & is_op & refuse;
  wire clr_st = cmd_wr & rewr_en_r & ~busy_r & (cmd == `FRAC_CMD_CLRST);
  wire rd_st = cmd_wr & rewr_en_r & ~busy_r & ~mode_sel_r &
               (cmd == `FRAC_CMD_RDSTAT);
  wire fin = busy_r & op_done;

  // ****************************************
  // Control bits; rewrite enable, lock disable and mode select need 0-then-1 arming
  // ****************************************
  wire c0_wr = wr & (paddr == `FRAC_OFS_CTRL0);
  wire c1_wr = wr & (paddr == `FRAC_OFS_CTRL1);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rewr_en_r <= 1'b0;
      lock_dis_r <= 1'b0;
      area_sel_r <= 1'b0;
      mode_sel_r <= 1'b0;
      arm_en_r <= 1'b0;
      arm_mode_r <= 1'b0;
      arm_ld_r <= 1'b0;
      ctl_blk_r <= 4'h0;
    end else begin
      if (c0_wr) begin
        area_sel_r <= pwdata[`FRAC_C0_AREA_SEL];
        if (!pwdata[`FRAC_C0_REWR_EN]) begin
          rewr_en_r <= 1'b0;
          arm_en_r <= 1'b1;
        end else if (arm_en_r) begin
          rewr_en_r <= 1'b1;
          arm_en_r <= 1'b0;
        end
        if (!pwdata[`FRAC_C0_LOCK_DIS]) begin
          lock_dis_r <= 1'b0;
          arm_ld_r <= rewr_en_r;
        end else if (arm_ld_r && rewr_en_r) begin
          lock_dis_r <= 1'b1;
          arm_ld_r <= 1'b0;
        end
      end
      if (c1_wr) begin
        if (!pwdata[`FRAC_C1_MODE_SEL]) begin
          mode_sel_r <= 1'b0;
          arm_mode_r <= 1'b1;
        end else if (arm_mode_r && rewr_en_r) begin
          mode_sel_r <= 1'b1;
          arm_mode_r <= 1'b0;
        end
      end
      if (wr && (paddr == `FRAC_OFS_CTLBLK)) begin
        ctl_blk_r <= pwdata[3:0];
      end
    end
  end

  // ****************************************
  // Operation sequencer and status flags
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      cur_cmd_r <= 3'h0;
      cur_blk_r <= 4'h0;
      op_req <= 1'b0;
      op_cmd <= 3'h0;
      op_block <= 4'h0;
      perr_r <= 1'b0;
      eerr_r <= 1'b0;
      lock_stat_r <= 1'b0;
      read_status_mode <= 1'b0;
      cpu_hold <= 1'b0;
    end else begin
      op_req <= go;
      if (go) begin
        busy_r <= 1'b1;
        cur_cmd_r <= cmd;
        cur_blk_r <= cblk;
        op_cmd <= cmd;
        op_block <= cblk;
        cpu_hold <= mode_sel_r;
      end else if (fin) begin
        busy_r <= 1'b0;
        cpu_hold <= 1'b0;
        read_status_mode <= ~mode_sel_r;
      end else if (rd_st) begin
        read_status_mode <= 1'b1;
      end
      if (fin && (cur_cmd_r == `FRAC_CMD_LOCKRD)) begin
        lock_stat_r <= lock_r[cur_blk_r[2:0]];
      end
      // A setting event outranks the clear command
      if ((fin && op_fail && !(cur_cmd_r == `FRAC_CMD_BERASE ||
           cur_cmd_r == `FRAC_CMD_EALL)) || (bad && !is_erase)) begin
        perr_r <= 1'b1;
      end else if (clr_st) begin
        perr_r <= 1'b0;
      end
      if ((fin && op_fail && (cur_cmd_r == `FRAC_CMD_BERASE ||
           cur_cmd_r == `FRAC_CMD_EALL)) || (bad && is_erase)) begin
        eerr_r <= 1'b1;
      end else if (clr_st) begin
        eerr_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Lock bits updated at completion; protect byte at erase completion or on write
  // ****************************************
  wire fin_ok = fin & ~op_fail;
  wire fin_ber = fin_ok & (cur_cmd_r == `FRAC_CMD_BERASE);
  wire fin_eall = fin_ok & (cur_cmd_r == `FRAC_CMD_EALL);
  genvar gi;
  generate
    for (gi = 0; gi < NBLK; gi = gi + 1) begin : g_lock
      wire hit = (cur_blk_r == gi);
      wire erased = (fin_ber & hit) | (fin_eall & (lock_r[gi] | lock_dis_r));
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lock_r[gi] <= 1'b1;
        end else if (fin_ok && hit && (cur_cmd_r == `FRAC_CMD_LOCKPRG)) begin
          lock_r[gi] <= 1'b0;
        end else if (erased && lock_dis_r) begin
          lock_r[gi] <= 1'b1;
        end
      end
    end
  endgenerate
  wire cp_erased = (fin_ber & (cur_blk_r == CP_BLOCK)) |
                   (fin_eall & (lock_r[CP_BLOCK] | lock_dis_r));
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpb_r <= `FRAC_CPB_RESET;
    end else if (cp_erased) begin
      cpb_r <= `FRAC_CPB_ERASED;
    end else if (wr && (paddr == `FRAC_OFS_CPB) && rewr_en_r && area_ok &&
                 !busy_r) begin
      cpb_r <= pwdata[7:0];
    end
  end

  // ****************************************
  // Serial programmer ID verification
  // ****************************************
  reg [2:0] id_cnt_r;
  reg id_bad_r;
  wire [7:0] id_ref = stored_id[{id_cnt_r, 3'h0} +: 8];
  wire blank_vec = (reset_vector == `FRAC_VEC_BLANK);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_cnt_r <= 3'h0;
      id_bad_r <= 1'b0;
      ser_accept <= 1'b0;
    end else if (!ser_mode_s) begin
      id_cnt_r <= 3'h0;
      id_bad_r <= 1'b0;
      ser_accept <= 1'b0;
    end else if (blank_vec) begin
      ser_accept <= 1'b1;
    end else if (id_valid && (id_cnt_r != `FRAC_ID_BYTES)) begin
      id_cnt_r <= id_cnt_r + 3'h1;
      if (id_cnt_r == `FRAC_ID_BYTES - 3'h1) begin
        ser_accept <= ~id_bad_r & (id_byte == id_ref);
      end
      if (id_byte != id_ref) begin
        id_bad_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // Mapping and parallel-mode outputs
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_area_sel <= 1'b0;
      par_blocked <= 1'b0;
    end else begin
      // One address window: boot area visible only in boot mode with select 0
      boot_area_sel <= boot_mode & ~area_sel_r;
      par_blocked <= par_mode_s & cp_active;
    end
  end

  // ****************************************
  // APB read path
  // ****************************************
  reg [31:0] rd_nxt;
  reg err_nxt;
  always @* begin
    rd_nxt = 32'h00000000;
    err_nxt = 1'b0;
    if (paddr == `FRAC_OFS_CTRL0) begin
      rd_nxt[`FRAC_C0_READY] = ~busy_r;
      rd_nxt[`FRAC_C0_REWR_EN] = rewr_en_r;
      rd_nxt[`FRAC_C0_LOCK_DIS] = lock_dis_r;
      rd_nxt[`FRAC_C0_AREA_SEL] = area_sel_r;
      rd_nxt[`FRAC_C0_PERR] = perr_r;
      rd_nxt[`FRAC_C0_EERR] = eerr_r;
    end else if (paddr == `FRAC_OFS_CTRL1) begin
      rd_nxt[`FRAC_C1_MODE_SEL] = mode_sel_r;
      rd_nxt[`FRAC_C1_LOCK_STAT] = lock_stat_r;
    end else if (paddr == `FRAC_OFS_CMD) begin
      rd_nxt[2:0] = cur_cmd_r;
    end else if (paddr == `FRAC_OFS_SRD) begin
      if (mode_sel_r) begin
        err_nxt = 1'b1;
      end else begin
        rd_nxt[`FRAC_SR_READY] = ~busy_r;
        rd_nxt[`FRAC_SR_EERR] = eerr_r;
        rd_nxt[`FRAC_SR_PERR] = perr_r;
      end
    end else if (paddr == `FRAC_OFS_LOCK) begin
      rd_nxt[NBLK-1:0] = lock_r;
    end else if (paddr == `FRAC_OFS_CPB) begin
      rd_nxt[7:0] = cpb_r;
    end else if (paddr == `FRAC_OFS_CTLBLK) begin
      rd_nxt[3:0] = ctl_blk_r;
    end else if (paddr == `FRAC_OFS_INFO) begin
      rd_nxt[3:0] = {ser_accept, par_blocked, boot_area_sel, boot_mode};
    end else begin
      err_nxt = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= bus_ph;
      pslverr <= bus_ph & err_nxt & (~pwrite | (paddr != `FRAC_OFS_SRD));
      prdata <= (bus_ph && !pwrite) ? rd_nxt : 32'h00000000;
    end
  end
endmodule

// [testbench/frac_flash_model.sv]
// Behavioural flash macro answering the controller's operation port.
// Assumes one operation at a time; latency and failure set by the bench.
`timescale 1ns/1ps
module frac_flash_model (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Operation port
  input wire op_req,
  output reg op_done,
  output reg op_fail,
  // Bench controls
  input wire [7:0] delay,
  input wire fail_en
);
  reg [7:0] cnt_r;
  reg busy_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      busy_r <= 1'b0;
      op_done <= 1'b0;
      op_fail <= 1'b0;
    end else begin
      op_done <= 1'b0;
      // Meaningless outside a done pulse, so keep it moving
      op_fail <= ~op_fail;
      if (op_req) begin
        busy_r <= 1'b1;
        cnt_r <= delay;
      end else if (busy_r && cnt_r == 8'h00) begin
        busy_r <= 1'b0;
        op_done <= 1'b1;
        op_fail <= fail_en;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule

// [testbench/frac_ctrl_assertions.sv]
// Port checks for the flash rewrite access controller.
// Assumes it is bound into frac_ctrl; single pclk domain.
`timescale 1ns/1ps
module frac_ctrl_assertions (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Observed ports
  input wire op_req,
  input wire op_done,
  input wire cpu_hold,
  input wire read_status_mode,
  input wire boot_mode,
  input wire boot_area_sel,
  input wire par_mode_pin,
  input wire par_blocked,
  input wire ser_mode_pin,
  input wire ser_accept,
  input wire id_valid,
  input wire [31:0] reset_vector
);
  reg [3:0] up_r;
  reg busy_r;
  reg [2:0] idcnt_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_r <= 4'h0;
      busy_r <= 1'b0;
      idcnt_r <= 3'h0;
    end else begin
      if (up_r != 4'hf)
        up_r <= up_r + 4'h1;
      if (op_req)
        busy_r <= 1'b1;
      else if (op_done)
        busy_r <= 1'b0;
      if (!ser_mode_pin)
        idcnt_r <= 3'h0;
      else if (id_valid && idcnt_r != 3'h7)
        idcnt_r <= idcnt_r + 3'h1;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************
  // Properties
  // ****************************************
  AST_BOOT_FIXED: assert property (up_r == 4'hf |-> $stable(boot_mode))
    else $error("boot mode changed after capture");
  AST_AREA_BOOT: assert property (boot_area_sel |-> boot_mode)
    else $error("boot area mapped outside boot mode");
  AST_ONE_OP: assert property (busy_r |-> !op_req)
    else $error("operation started while busy");
  AST_HOLD_RISE: assert property ($rose(cpu_hold) |-> op_req)
    else $error("hold without operation start");
  AST_HOLD_END: assert property (op_done && busy_r |=> !cpu_hold)
    else $error("hold not released after done");
  AST_MODE_ONE_END: assert property (op_done && busy_r && cpu_hold |=> !read_status_mode)
    else $error("mode one did not return to array read");
  AST_MODE_ZERO_END: assert property (op_done && busy_r && !cpu_hold
    |=> read_status_mode)
    else $error("mode zero did not enter status read");
  AST_PAR_OFF: assert property (!par_mode_pin [*4] |-> !par_blocked)
    else $error("parallel block outside parallel mode");
  AST_SER_ID: assert property ($rose(ser_accept) |->
    reset_vector == 32'hffffffff || idcnt_r == 3'h7)
    else $error("serial accept before seven id bytes");
  AST_SER_OFF: assert property (!ser_mode_pin [*4] |-> !ser_accept)
    else $error("serial accept outside serial mode");
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the flash rewrite access controller.
// Assumes frac_ctrl defaults NBLK=8, CP_BLOCK=0 and the flash model.
`timescale 1ns/1ps
`include "frac_defines.vh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, reset_vector;
  logic boot_select_pin, port5_bit0_strap, port5_bit5_strap, par_mode_pin, ser_mode_pin;
  logic id_valid, op_req, op_done, op_fail, fail_en;
  logic boot_mode, boot_area_sel, read_status_mode, cpu_hold, par_blocked, ser_accept;
  logic [7:0] id_byte, delay, pb;
  logic [55:0] stored_id;
  logic [2:0] op_cmd;
  logic [3:0] op_block;
  integer fails, compares, seed, i;

  frac_ctrl u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .boot_select_pin(boot_select_pin), .port5_bit0_strap(port5_bit0_strap),
    .port5_bit5_strap(port5_bit5_strap), .par_mode_pin(par_mode_pin),
    .ser_mode_pin(ser_mode_pin), .id_valid(id_valid), .id_byte(id_byte),
    .stored_id(stored_id), .reset_vector(reset_vector), .op_req(op_req), .op_cmd(op_cmd),
    .op_block(op_block), .op_done(op_done), .op_fail(op_fail), .boot_mode(boot_mode),
    .boot_area_sel(boot_area_sel), .read_status_mode(read_status_mode),
    .cpu_hold(cpu_hold), .par_blocked(par_blocked), .ser_accept(ser_accept));
  frac_flash_model u_flash (.pclk(pclk), .presetn(presetn), .op_req(op_req),
    .op_done(op_done), .op_fail(op_fail), .delay(delay), .fail_en(fail_en));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task give_verdict;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // Parallel access blocked while protect level is on and byte neither clear nor blank
  function [31:0] exp_info(input [7:0] b);
    begin
      exp_info = 32'h1;
      if (b[7:6] != 2'b11 && b != 8'h00 && b != 8'hff)
        exp_info = 32'h5;
    end
  endfunction

  // Answer taken at the edge where pready is seen high, then released
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
        fails = fails + 1;
        give_verdict;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
    end
  endtask

  task cmd(input logic [2:0] c, input logic [3:0] b);
    integer n;
    begin
      apb(1'b1, `FRAC_OFS_CMD, {20'h0, b, 5'h0, c});
      n = 0;
      do begin
        apb(1'b0, `FRAC_OFS_CTRL0, 32'h0);
        n = n + 1;
      end while (rd[0] !== 1'b1 && n < 200);
      if (n >= 200) begin
        fails = fails + 1;
        give_verdict;
      end
    end
  endtask

  task ser(input logic [55:0] s, input logic [31:0] v, input logic e);
    begin
      reset_vector <= v;
      ser_mode_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      for (i = 0; i < 7; i = i + 1) begin
        id_valid <= 1'b1;
        id_byte <= s[8*i +: 8];
        @(posedge pclk);
      end
      id_valid <= 1'b0;
      repeat (3) @(negedge pclk);
      chk("ser_accept", {31'h0, e}, {31'h0, ser_accept});
      @(posedge pclk);
      ser_mode_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      $display("test serial done");
    end
  endtask

  task do_reset(input logic bs);
    begin
      presetn <= 1'b0;
      boot_select_pin <= bs;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 98614;
    fails = 0;
    compares = 0;
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {port5_bit0_strap, port5_bit5_strap, boot_select_pin} = 3'b101;
    {par_mode_pin, ser_mode_pin, id_valid, id_byte, fail_en, delay} = '0;
    reset_vector = 32'h0;
    stored_id[31:0] = $random(seed);
    stored_id[55:32] = 24'($random(seed));
    do_reset(1'b1);
    rdc("info", `FRAC_OFS_INFO, 32'h3);
    rdc("ctrl0", `FRAC_OFS_CTRL0, 32'h1);
    rdc("cpb", `FRAC_OFS_CPB, 32'hff);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, `FRAC_OFS_CTRL0, 32'h0);
    apb(1'b1, `FRAC_OFS_CTRL0, 32'h2);
    cmd(`FRAC_CMD_PROG, 4'h1);
    rdc("ctrl0", `FRAC_OFS_CTRL0, 32'h43);
    apb(1'b1, `FRAC_OFS_CTRL0, 32'h22);
    rdc("info", `FRAC_OFS_INFO, 32'h1);
    cmd(`FRAC_CMD_CLRST, 4'h0);
    rdc("ctrl0", `FRAC_OFS_CTRL0, 32'h23);
    $display("test boot done");
    // Bench issues commands as control code in RAM would; no flash fetches
    for (i = 0; i < 3; i = i + 1) begin
      delay <= 8'($random(seed));
      cmd(`FRAC_CMD_PROG, 4'($random(seed)) & 4'h7);
      rdc("status", `FRAC_OFS_SRD, 32'h80);
      chk("rsm", 32'h1, {31'h0, read_status_mode});
    end
    cmd(`FRAC_CMD_LOCKPRG, 4'h2);
    rdc("lock", `FRAC_OFS_LOCK, 32'hfb);
    cmd(`FRAC_CMD_PROG, 4'h2);
    rdc("ctrl0", `FRAC_OFS_CTRL0, 32'h63);
    cmd(`FRAC_CMD_BERASE, 4'h9);
    rdc("ctrl0", `FRAC_OFS_CTRL0, 32'he3);
    cmd(`FRAC_CMD_CLRST, 4'h0);
    fail_en <= 1'b1;
    cmd(`FRAC_CMD_PROG, 4'h4);
    rdc("ctrl0", `FRAC_OFS_CTRL0, 32'h63);
    fail_en <= 1'b0;
    cmd(`FRAC_CMD_CLRST, 4'h0);
    $display("test mode zero done");
    par_mode_pin <= 1'b1;
    // Four fixed levels, then random ones; low six bits always ones
    for (i = 0; i < 8; i = i + 1) begin
      pb = (i < 4) ? 8'(i * 64 + 63) : {2'($random(seed)), 6'h3f};
      apb(1'b1, `FRAC_OFS_CPB, {24'h0, pb});
      rdc("info", `FRAC_OFS_INFO, exp_info(pb));
    end
    apb(1'b1, `FRAC_OFS_CPB, 32'h0);
    rdc("info", `FRAC_OFS_INFO, 32'h1);
    apb(1'b1, `FRAC_OFS_CPB, 32'h7f);
    cmd(`FRAC_CMD_BERASE, 4'h0);
    rdc("cpb", `FRAC_OFS_CPB, 32'hff);
    rdc("info", `FRAC_OFS_INFO, 32'h1);
    par_mode_pin <= 1'b0;
    $display("test protect done");
    apb(1'b1, `FRAC_OFS_CTRL1, 32'h0);
    apb(1'b1, `FRAC_OFS_CTRL1, 32'h2);
    rdc("ctrl1", `FRAC_OFS_CTRL1, 32'h2);
    apb(1'b1, `FRAC_OFS_CTLBLK, 32'h3);
    cmd(`FRAC_CMD_PROG, 4'h3);
    rdc("ctrl0", `FRAC_OFS_CTRL0, 32'h63);
    cmd(`FRAC_CMD_EALL, 4'h0);
    rdc("ctrl0", `FRAC_OFS_CTRL0, 32'he3);
    apb(1'b0, `FRAC_OFS_SRD, 32'h0);
    chk("srd err", 32'h1, {31'h0, err});
    cmd(`FRAC_CMD_CLRST, 4'h0);
    cmd(`FRAC_CMD_LOCKPRG, 4'h3);
    cmd(`FRAC_CMD_EALL, 4'h0);
    rdc("lock", `FRAC_OFS_LOCK, 32'hf3);
    delay <= 8'h20;
    apb(1'b1, `FRAC_OFS_CMD, {20'h0, 4'h5, 5'h0, `FRAC_CMD_PROG});
    rdc("ctrl0 busy", `FRAC_OFS_CTRL0, 32'h22);
    chk("cpu_hold", 32'h1, {31'h0, cpu_hold});
    chk("op_cmd", {29'h0, `FRAC_CMD_PROG}, {29'h0, op_cmd});
    chk("op_block", 32'h5, {28'h0, op_block});
    // Clear status is ignored while busy; the call only waits for ready
    cmd(`FRAC_CMD_CLRST, 4'h0);
    rdc("ctrl0", `FRAC_OFS_CTRL0, 32'h23);
    chk("cpu_hold", 32'h0, {31'h0, cpu_hold});
    chk("rsm", 32'h0, {31'h0, read_status_mode});
    $display("test mode one done");
    ser(stored_id, 32'h0, 1'b1);
    ser(stored_id ^ 56'h01000000000000, 32'h0, 1'b0);
    ser(~stored_id, 32'hffffffff, 1'b1);
    do_reset(1'b0);
    rdc("info", `FRAC_OFS_INFO, 32'h0);
    $display("test user boot done");
    give_verdict;
  end
endmodule

bind frac_ctrl frac_ctrl_assertions u_chk (.pclk(pclk), .presetn(presetn), .op_req(op_req),
  .op_done(op_done), .cpu_hold(cpu_hold), .read_status_mode(read_status_mode),
  .boot_mode(boot_mode), .boot_area_sel(boot_area_sel), .par_mode_pin(par_mode_pin),
  .par_blocked(par_blocked), .ser_mode_pin(ser_mode_pin), .ser_accept(ser_accept),
  .id_valid(id_valid), .reset_vector(reset_vector));
